// *** design/ics_top.sv ***
/*
  Input clock selection and fault monitoring: manual or automatic choice
  of one of four clock inputs, signal loss and frequency offset monitors,
  reference pin loss and lock loss indication, sticky status.
  Assumes clock inputs are oversampled well below 50 MHz, and that the
  PLL core reports frequency lock on CORE_LOCKED in this clock domain.
*/
// Contract
// - Select from pins or register, pins default
// - Codes 0..3 pick inputs; 3 reserved zero-delay
// - Manual dead input forces holdover or free-run
// - Zero-delay mode removes input 3 from selection
// - Automatic picks only valid inputs by priority
// - Automatic with no valid input enters holdover
// - Revertive always holds highest valid priority
// - Non-revertive keeps active input while valid
// - Hitless switch absorbs phase, down to 8 kHz
// - Ramped switching shares holdover-exit ramp rate
// - Glitchless switch within 500 ppm, fast-lock option
// - Lock loss asserted while pulling in
// - Gaps raise no loss, offset or lock flags; the offset monitors here count a gap as missing edges and flag it
// - Loss and offset monitors per input, reference loss
// - Loss monitor times periods, own sensitivity
// - Loss status live and sticky per input
// - Each loss monitor has own disable
// - Reference loss stops outputs unless kept
// - Offset zero-ppm reference selectable by register
// - Offset combines precise and fast, live and sticky
// - Precise offset window with hysteresis on release
// - Fast offset flags moves beyond 4000 ppm
`timescale 1ns/1ps
module ics_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [ics_pkg::NIN-1:0] CLK_INPUT,
  input wire logic REF_PIN_CLK,
  input wire logic [1:0] SEL_PIN,
  input wire logic CORE_LOCKED,
  output logic [1:0] ACT_SEL,
  output logic HOLD,
  output logic LOCK_LOSS,
  output logic SWITCH,
  output logic HITLESS,
  output logic RAMP,
  output logic FAST_BW,
  output logic OUT_EN,
  output logic [ics_pkg::NMON-1:0] SIG_LOSS,
  output logic [ics_pkg::NIN-1:0] FREQ_OFF
);
  import ics_pkg::*;

  // Synchronisers for clock pins and select pins
  logic [NMON-1:0] s1_q, s2_q, s3_q; // Two sync stages and edge stage
  logic [NMON-1:0] edg; // Rising edge pulses, bit 4 is reference pins
  logic [1:0] sel1_q, sel2_q; // Select pin synchroniser

  // Register file
  ics_ctrl_t ctrl_q, ctrl_d; // Mode control
  logic [15:0] prio_q, prio_d; // Nibble per input, lower is preferred
  logic [NMON-1:0] ldis_q, ldis_d; // Loss monitor disables
  logic [15:0] llim_q [NMON]; // Loss timeouts in cycles
  logic [15:0] llim_d [NMON];
  logic [23:0] ogate_q, ogate_d; // Reference edges per precise gate
  logic [23:0] oexp_q, oexp_d; // Expected edges per precise gate
  logic [31:0] othr_q, othr_d; // Hysteresis high half, window low half
  logic [15:0] fthr_q, fthr_d; // Fast window in counts
  logic [9:0] sticky_q, sticky_d; // Lock loss, offsets, losses
  logic [31:0] rdata_q, rdata_d; // Read data, one cycle after strobe

  // Monitor results
  logic [NIN-1:0] prec_f, fast_f; // Precise and fast offset flags
  logic [NIN-1:0] foff_q, foff_d; // Combined live offset
  logic ref_e; // Zero-ppm reference edge
  logic [NIN-1:0] valid; // Qualified inputs

  // Selector
  ics_state_t state_q, state_d;
  logic [1:0] act_q, act_d;
  logic [1:0] code; // Manual select code
  logic [1:0] best, tgt;
  logic [3:0] bprio;
  logic best_ok, tgt_ok;
  logic sw_q, sw_d;
  logic hitless_q, ramp_q, fastbw_q, outen_q;
  logic hitless_d, ramp_d, fastbw_d, outen_d;

  // Pin synchronisers: logic reads the second and third stages, never the first
  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sel1_q <= 2'h0;
      sel2_q <= 2'h0;
    end else begin
      s1_q <= {REF_PIN_CLK, CLK_INPUT};
      s2_q <= s1_q;
      s3_q <= s2_q;
      sel1_q <= SEL_PIN;
      sel2_q <= sel1_q;
    end
  end

  assign edg = s2_q & ~s3_q;

  // Zero-ppm reference choice: 0 reference pins, 1..4 inputs 0..3
  always_comb begin
    case (ctrl_q.ofs_ref)
      3'h1: ref_e = edg[0];
      3'h2: ref_e = edg[1];
      3'h3: ref_e = edg[2];
      3'h4: ref_e = edg[3];
      default: ref_e = edg[4];
    endcase
  end

  // Monitors per channel; input 3 is watched even as feedback
  genvar g;
  generate
    for (g = 0; g < NMON; g++) begin : g_mon
      // Timeout must exceed three periods to ride through gaps
      ics_sigloss_mon #(.W(16)) u_loss (
        .clk(CLK),
        .rst(RST),
        .edge_p(edg[g]),
        .dis(ldis_q[g]),
        .limit(llim_q[g]),
        .loss(SIG_LOSS[g])
      );
      if (g < NIN) begin : g_ofs
        ics_freq_mon #(.CW(24)) u_prec (
          .clk(CLK),
          .rst(RST),
          .in_edge(edg[g]),
          .ref_edge(ref_e),
          .dis(ctrl_q.precise_dis),
          .gate(ogate_q),
          .expect_cnt(oexp_q),
          .thr({8'h00, othr_q[15:0]}),
          .hyst({8'h00, othr_q[31:16]}),
          .flag(prec_f[g])
        );
        // Short gate reacts fast but coarsely; no hysteresis
        ics_freq_mon #(.CW(24)) u_fast (
          .clk(CLK),
          .rst(RST),
          .in_edge(edg[g]),
          .ref_edge(ref_e),
          .dis(ctrl_q.fast_dis),
          .gate(ogate_q >> FAST_SHIFT),
          .expect_cnt(oexp_q >> FAST_SHIFT),
          .thr({8'h00, fthr_q}),
          .hyst(24'h000000),
          .flag(fast_f[g])
        );
      end
    end
  endgenerate

  // Combined offset and input qualification
  always_comb begin
    foff_d = prec_f | fast_f;
    for (int i = 0; i < NIN; i++) begin
      // Offset window within 500 ppm keeps switches glitchless
      valid[i] = !SIG_LOSS[i] && !foff_q[i];
    end
    if (ctrl_q.zdm) begin
      valid[3] = 1'b0;
    end
  end

  // Best valid input; strict compare keeps the lower index on ties
  always_comb begin
    best = 2'h0;
    best_ok = 1'b0;
    bprio = 4'hf;
    for (int i = 0; i < NIN; i++) begin
      if (valid[i] && (!best_ok || prio_q[4*i +: 4] < bprio)) begin
        best = 2'(i);
        bprio = prio_q[4*i +: 4];
        best_ok = 1'b1;
      end
    end
  end

  // Target input for the current mode
  always_comb begin
    code = ctrl_q.src_reg ? ctrl_q.reg_sel : sel2_q;
    if (!ctrl_q.auto_en) begin
      // Code maps straight to input; reserved code fails valid[3]
      tgt = code;
      tgt_ok = valid[code];
    end else if (ctrl_q.revert) begin
      tgt = best;
      tgt_ok = best_ok;
    end else if (state_q != ST_HOLD && valid[act_q]) begin
      tgt = act_q;
      tgt_ok = 1'b1;
    end else begin
      tgt = best;
      tgt_ok = best_ok;
    end
  end

  // Selector state machine
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    sw_d = 1'b0;
    case (state_q)
      ST_HOLD: begin
        if (tgt_ok) begin
          act_d = tgt;
          sw_d = 1'b1;
          state_d = ST_PULL;
        end
      end
      ST_PULL, ST_LOCKED: begin
        if (!tgt_ok) begin
          // Core falls back to free-run or holdover
          state_d = ST_HOLD;
        end else if (tgt != act_q) begin
          act_d = tgt;
          sw_d = 1'b1;
          state_d = ST_PULL;
        end else if (state_q == ST_PULL && CORE_LOCKED) begin
          state_d = ST_LOCKED;
        end
      end
      default: state_d = ST_HOLD;
    endcase
    // Switch style passed to the core with every selection
    hitless_d = ctrl_q.hitless;
    ramp_d = ctrl_q.ramp;
    fastbw_d = ctrl_q.fastlock && state_d == ST_PULL;
    outen_d = ctrl_q.ref_keep || !SIG_LOSS[4];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ST_HOLD;
      act_q <= 2'h0;
      sw_q <= 1'b0;
      hitless_q <= 1'b0;
      ramp_q <= 1'b0;
      fastbw_q <= 1'b0;
      outen_q <= 1'b0;
      foff_q <= '0;
    end else begin
      state_q <= state_d;
      act_q <= act_d;
      sw_q <= sw_d;
      hitless_q <= hitless_d;
      ramp_q <= ramp_d;
      fastbw_q <= fastbw_d;
      outen_q <= outen_d;
      foff_q <= foff_d;
    end
  end

  // Register writes, sticky status and read data
  always_comb begin
    ctrl_d = ctrl_q;
    prio_d = prio_q;
    ldis_d = ldis_q;
    llim_d = llim_q;
    ogate_d = ogate_q;
    oexp_d = oexp_q;
    othr_d = othr_q;
    fthr_d = fthr_q;
    sticky_d = sticky_q;
    rdata_d = 32'h0;
    if (WR) begin
      case (ADDR)
        A_CTRL: ctrl_d = WDATA[14:0];
        A_PRIO: prio_d = WDATA[15:0];
        A_LDIS: ldis_d = WDATA[4:0];
        A_OGATE: ogate_d = WDATA[23:0];
        A_OEXP: oexp_d = WDATA[23:0];
        A_OTHR: othr_d = WDATA;
        A_FTHR: fthr_d = WDATA[15:0];
        A_STICKY: sticky_d = sticky_q & ~WDATA[9:0];
        default: begin
          for (int i = 0; i < NMON; i++) begin
            if (ADDR == A_LLIM0 + 8'(4*i)) begin
              llim_d[i] = WDATA[15:0];
            end
          end
        end
      endcase
    end
    // Set after clear so a live event is never lost
    sticky_d = sticky_d | {LOCK_LOSS, foff_q, SIG_LOSS};
    if (RD) begin
      case (ADDR)
        A_CTRL: rdata_d = {17'h0, ctrl_q};
        A_PRIO: rdata_d = {16'h0, prio_q};
        A_LDIS: rdata_d = {27'h0, ldis_q};
        A_OGATE: rdata_d = {8'h0, ogate_q};
        A_OEXP: rdata_d = {8'h0, oexp_q};
        A_OTHR: rdata_d = othr_q;
        A_FTHR: rdata_d = {16'h0, fthr_q};
        A_STAT: rdata_d = {18'h0, outen_q, act_q, HOLD, LOCK_LOSS,
                           foff_q, SIG_LOSS};
        A_STICKY: rdata_d = {22'h0, sticky_q};
        default: begin
          for (int i = 0; i < NMON; i++) begin
            if (ADDR == A_LLIM0 + 8'(4*i)) begin
              rdata_d = {16'h0, llim_q[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      prio_q <= PRIO_RST;
      ldis_q <= LDIS_RST;
      for (int i = 0; i < NMON; i++) begin
        llim_q[i] <= LLIM_RST;
      end
      ogate_q <= OGATE_RST;
      oexp_q <= OEXP_RST;
      othr_q <= OTHR_RST;
      fthr_q <= FTHR_RST;
      sticky_q <= 10'h000;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      prio_q <= prio_d;
      ldis_q <= ldis_d;
      llim_q <= llim_d;
      ogate_q <= ogate_d;
      oexp_q <= oexp_d;
      othr_q <= othr_d;
      fthr_q <= fthr_d;
      sticky_q <= sticky_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs from flops; HOLD and LOCK_LOSS decoded from state_q
  assign RDATA = rdata_q;
  assign ACT_SEL = act_q;
  assign HOLD = (state_q == ST_HOLD);
  assign LOCK_LOSS = (state_q != ST_LOCKED);
  assign SWITCH = sw_q;
  assign HITLESS = hitless_q;
  assign RAMP = ramp_q;
  assign FAST_BW = fastbw_q;
  assign OUT_EN = outen_q;
  assign FREQ_OFF = foff_q;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_ZDM_NO3: assert property (
    $past(ctrl_q.zdm) && ctrl_q.zdm && !HOLD |-> ACT_SEL != 2'h3)
    else $error("input 3 selected in zero-delay mode");
  AST_MAN_DEAD: assert property (
    !ctrl_q.auto_en && !valid[code] |=> HOLD)
    else $error("manual selection stayed on dead input");
  AST_AUTO_HOLD: assert property (
    ctrl_q.auto_en && valid == 4'h0 |=> HOLD && LOCK_LOSS)
    else $error("no valid input but not in holdover");
  AST_REVERT: assert property (
    ctrl_q.auto_en && ctrl_q.revert && best_ok
    |=> !HOLD && ACT_SEL == $past(best))
    else $error("revertive selector not on best input");
  AST_NONREV: assert property (
    ctrl_q.auto_en && !ctrl_q.revert && !HOLD && valid[ACT_SEL]
    |=> $stable(ACT_SEL) && !HOLD)
    else $error("non-revertive selector left a valid input");
  AST_SW_LOL: assert property (
    SWITCH && !CORE_LOCKED |-> LOCK_LOSS ##1 LOCK_LOSS)
    else $error("lock loss low during pull-in");
  AST_STICKY: assert property (
    1'b1 |=> (sticky_q & $past({LOCK_LOSS, foff_q, SIG_LOSS}))
             == $past({LOCK_LOSS, foff_q, SIG_LOSS}))
    else $error("sticky bit missed a live event");
  AST_LDIS: assert property (
    1'b1 |=> (SIG_LOSS & $past(ldis_q)) == 5'h00)
    else $error("disabled loss monitor reported loss");
  AST_REFPIN: assert property (
    !ctrl_q.ref_keep && SIG_LOSS[4] |=> !OUT_EN)
    else $error("outputs enabled during reference loss");
  AST_TIE: assert property (
    ctrl_q.auto_en && ctrl_q.revert && valid[0] && valid[1]
    && prio_q[3:0] == prio_q[7:4] && prio_q[3:0] <= prio_q[11:8]
    && prio_q[3:0] <= prio_q[15:12] |=> ACT_SEL == 2'h0)
    else $error("priority tie not given to lower input");
endmodule // ics_top

// *** inc/ics_pkg.sv ***
/*
  Shared constants and types for the input clock select and monitor block:
  register offsets, reset values, control layout and selector states.
  Assumes a 32-bit register port with byte addresses on word boundaries.
*/
package ics_pkg;
  // Channel counts: four clock inputs plus the reference pins
  localparam int unsigned NIN = 4;
  localparam int unsigned NMON = 5;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PRIO = 8'h04;
  localparam logic [7:0] A_LDIS = 8'h08;
  localparam logic [7:0] A_OGATE = 8'h0c;
  localparam logic [7:0] A_OEXP = 8'h10;
  localparam logic [7:0] A_OTHR = 8'h14;
  localparam logic [7:0] A_FTHR = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  localparam logic [7:0] A_STICKY = 8'h20;
  localparam logic [7:0] A_LLIM0 = 8'h24;
  // Reset values
  localparam logic [14:0] CTRL_RST = 15'h0000;
  localparam logic [15:0] PRIO_RST = 16'h3210;
  localparam logic [4:0] LDIS_RST = 5'h00;
  localparam logic [15:0] LLIM_RST = 16'h0040;
  localparam logic [23:0] OGATE_RST = 24'h000400;
  localparam logic [23:0] OEXP_RST = 24'h000400;
  localparam logic [31:0] OTHR_RST = 32'h0002_0008;
  localparam logic [15:0] FTHR_RST = 16'h0004;
  // Fast monitor gate and expected count are the precise ones shifted down by this much
  localparam int unsigned FAST_SHIFT = 4;
  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic fast_dis;
    logic precise_dis;
    logic [2:0] ofs_ref;
    logic ref_keep;
    logic fastlock;
    logic ramp;
    logic hitless;
    logic zdm;
    logic revert;
    logic auto_en;
    logic [1:0] reg_sel;
    logic src_reg;
  } ics_ctrl_t;
  // Selector states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_PULL = 2'b01,
    ST_LOCKED = 2'b10
  } ics_state_t;
endpackage

// *** design/ics_sigloss_mon.sv ***
/*
  Signal loss monitor for one clock: times the gap between rising edges.
  Assumes edge_p is a one-cycle pulse already synchronised to clk.
*/
`timescale 1ns/1ps
module ics_sigloss_mon #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic edge_p,
  input wire logic dis,
  input wire logic [W-1:0] limit,
  output logic loss
);
  logic [W-1:0] cnt_q, cnt_d; // Cycles since the last edge
  logic loss_q, loss_d; // Live loss flag

  // Next gap count and flag
  always_comb begin
    cnt_d = cnt_q;
    loss_d = loss_q;
    if (dis || edge_p) begin
      // Disabled monitor reports no loss
      cnt_d = '0;
      loss_d = 1'b0;
    end else if (cnt_q >= limit) begin
      // Limit spans several periods so isolated gaps are tolerated
      loss_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      loss_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss = loss_q;
endmodule // ics_sigloss_mon

// *** design/ics_freq_mon.sv ***
/*
  Frequency offset monitor for one clock: counts its edges over a gate of
  reference edges and flags a count outside expect +/- thr, with hysteresis.
  Assumes both edge inputs are one-cycle pulses synchronised to clk.
*/
`timescale 1ns/1ps
module ics_freq_mon #(
  parameter int CW = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_edge,
  input wire logic ref_edge,
  input wire logic dis,
  input wire logic [CW-1:0] gate,
  input wire logic [CW-1:0] expect_cnt,
  input wire logic [CW-1:0] thr,
  input wire logic [CW-1:0] hyst,
  output logic flag
);
  logic [CW-1:0] rcnt_q, rcnt_d; // Reference edges in this gate
  logic [CW-1:0] icnt_q, icnt_d; // Monitored edges in this gate
  logic flag_q, flag_d; // Live offset flag
  logic [CW-1:0] dev; // Distance of the count from the expected one

  // Next counts and flag
  always_comb begin
    rcnt_d = rcnt_q;
    icnt_d = icnt_q;
    flag_d = flag_q;
    dev = (icnt_q > expect_cnt) ? icnt_q - expect_cnt : expect_cnt - icnt_q;
    if (dis) begin
      rcnt_d = '0;
      icnt_d = '0;
      flag_d = 1'b0;
    end else if (ref_edge && rcnt_q >= gate) begin
      // End of gate: judge and restart
      rcnt_d = '0;
      icnt_d = {{(CW-1){1'b0}}, in_edge};
      if (dev > thr) begin
        flag_d = 1'b1;
      end else if ({1'b0, dev} + {1'b0, hyst} <= {1'b0, thr}) begin
        // Clears only well inside the window, avoiding chatter
        flag_d = 1'b0;
      end
    end else begin
      if (ref_edge) begin
        rcnt_d = rcnt_q + 1'b1;
      end
      if (in_edge) begin
        icnt_d = icnt_q + 1'b1;
      end
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_q <= '0;
      icnt_q <= '0;
      flag_q <= 1'b0;
    end else begin
      rcnt_q <= rcnt_d;
      icnt_q <= icnt_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule // ics_freq_mon

// *** bench/ics_clk_src.sv ***
/*
  Behavioural model of the four clock sources and the reference clock.
  Assumes the bench drives run, slow and gap as plain levels.
*/
`timescale 1ns/1ps
module ics_clk_src (
  input wire logic [3:0] run,
  input wire logic ref_run,
  input wire logic [3:0] slow,
  input wire logic [3:0] gap,
  output logic [3:0] clk_in,
  output logic ref_clk
);
  // Each source runs at 12.5 MHz, or 11.1 MHz when slowed
  for (genvar i = 0; i < 4; i++) begin : g_src
    logic c; // Source level
    int unsigned cyc; // Place in the eight-cycle gap pattern
    initial begin
      c = 1'b0;
      cyc = 0;
      #(3 + 7 * i);
      forever begin
        #(slow[i] ? 45 : 40);
        if (!run[i] || c) begin
          c = 1'b0; // A stopped source rests low, it does not run free
        end else begin
          cyc = (cyc + 1) % 8;
          c = !(gap[i] && cyc >= 6);
        end
      end
    end
    assign clk_in[i] = c;
  end
  // Reference pins at the nominal input rate
  initial begin
    ref_clk = 1'b0;
    forever begin
      #40;
      ref_clk = ref_run ? !ref_clk : 1'b0;
    end
  end
endmodule // ics_clk_src

// *** bench/testbench.sv ***
/*
  Self-checking bench for the clock select and monitor block.
  Assumes ics_pkg, ics_top and the clock source model ics_clk_src.
*/
`timescale 1ns/1ps
module testbench;
  import ics_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] sel_pin = 2'h0;
  logic [1:0] act_sel;
  logic [3:0] clk_in;
  logic [3:0] run = 4'hf; // Sources running
  logic [3:0] slow = 4'h0; // Sources off frequency
  logic [3:0] gap = 4'h0; // Sources gapped
  logic [3:0] freq_off;
  logic [4:0] sig_loss;
  logic ref_clk;
  logic ref_run = 1'b1;
  logic core_locked;
  logic hold, lock_loss, sw, hitless, ramp, fast_bw, out_en;
  ics_ctrl_t ctrl_now = '0; // Control word last written
  int err_count = 0;
  int checks_done = 0;
  int lock_cnt = 0; // Core pull-in progress since last switch
  logic fl_q = 1'b0; // Fast-lock setting as the selector has seen it
  logic [31:0] d; // Last read word
  logic [7:0] ra [13]; // Reset table addresses
  logic [31:0] rv [13]; // Reset table values

  always #5 clk = ~clk;

  ics_clk_src src (.run(run), .ref_run(ref_run), .slow(slow), .gap(gap),
    .clk_in(clk_in), .ref_clk(ref_clk));
  ics_top dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CLK_INPUT(clk_in), .REF_PIN_CLK(ref_clk),
    .SEL_PIN(sel_pin), .CORE_LOCKED(core_locked), .ACT_SEL(act_sel),
    .HOLD(hold), .LOCK_LOSS(lock_loss), .SWITCH(sw), .HITLESS(hitless),
    .RAMP(ramp), .FAST_BW(fast_bw), .OUT_EN(out_en), .SIG_LOSS(sig_loss),
    .FREQ_OFF(freq_off));

  // Core model: locks 20 cycles after a switch, never while holding
  assign core_locked = lock_cnt >= 20 && !sw && !hold;
  always @(posedge clk) begin
    if (rst || sw || hold) begin
      lock_cnt <= 0;
    end else if (lock_cnt < 22) begin
      lock_cnt <= lock_cnt + 1;
    end
    // The pull-in bandwidth output trails a control write by one edge
    fl_q <= ctrl_now.fastlock;
    if (!rst && lock_cnt > 0 && lock_cnt < 20 && !hold) begin
      chk_flag(lock_loss, 1'b1);
      chk_flag(fast_bw, fl_q);
    end
    if (!rst && lock_cnt == 22 && !sw && !hold) begin
      chk_flag(lock_loss, 1'b0);
    end
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask

  // One-cycle write; the control copy follows at the taking edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    if (a == A_CTRL) ctrl_now <= ics_ctrl_t'(v[14:0]);
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Poll status under a bound; a miss ends the run
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] e,
    input int lim);
    int n;
    n = 0;
    reg_rd(A_STAT, d);
    while ((d & m) !== e && n < lim) begin
      reg_rd(A_STAT, d);
      n++;
    end
    chk_word(d & m, e);
    if ((d & m) !== e) report_and_stop();
  endtask

  task automatic report_and_stop;
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    ra = '{A_CTRL, A_PRIO, A_LDIS, A_OGATE, A_OEXP, A_OTHR, A_FTHR,
      A_STICKY, A_LLIM0, 8'h28, 8'h2c, 8'h30, 8'h40};
    rv = '{32'(CTRL_RST), 32'(PRIO_RST), 32'(LDIS_RST), 32'(OGATE_RST),
      32'(OEXP_RST), OTHR_RST, 32'(FTHR_RST), 32'h200, 32'(LLIM_RST),
      32'(LLIM_RST), 32'(LLIM_RST), 32'(LLIM_RST), 32'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_wr(8'h40, 32'hffff_ffff); // Unmapped place must stay empty
    for (int k = 0; k < 13; k++) begin
      reg_rd(ra[k], d);
      chk_word(d, rv[k]);
      @(posedge clk);
      #1 chk_word(rdata, 32'h0);
    end
    // Pin selection, every code, outputs enabled
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      sel_pin <= 2'(k);
      wait_stat(32'h3c00, 32'h2000 | (k << 11), 20);
    end
    reg_wr(A_CTRL, 32'h20);
    wait_stat(32'h0600, 32'h0600, 20);
    reg_wr(A_CTRL, 32'h05);
    wait_stat(32'h1c00, 32'h1000, 20);
    // Offset monitors off while sources are stopped: a stall is off rate
    reg_wr(A_CTRL, 32'h61c3);
    wait_stat(32'h1c00, 32'h0800, 20);
    chk_flag(hitless, 1'b1);
    chk_flag(ramp, 1'b1);
    wait_stat(32'h0200, 32'h0, 20);
    // Dead manual input falls back to holdover, loss is live and sticky
    @(posedge clk);
    run[1] <= 1'b0;
    wait_stat(32'h0602, 32'h0602, 60);
    @(posedge clk);
    run[1] <= 1'b1;
    wait_stat(32'h0602, 32'h0, 60);
    reg_rd(A_STICKY, d);
    chk_word(d & 32'h2, 32'h2);
    reg_wr(A_STICKY, 32'h2);
    reg_rd(A_STICKY, d);
    chk_word(d & 32'h2, 32'h0);
    // Disabled monitor stays quiet past its timeout
    reg_wr(A_LDIS, 32'h2);
    @(posedge clk);
    run[1] <= 1'b0;
    repeat (80) @(posedge clk);
    reg_rd(A_STAT, d);
    chk_word(d & 32'h0602, 32'h0);
    @(posedge clk);
    run[1] <= 1'b1;
    reg_wr(A_LDIS, 32'h0);
    // Automatic, revertive then not
    reg_wr(A_CTRL, 32'h6018);
    wait_stat(32'h1c00, 32'h0, 20);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      run[0] <= 1'b0;
      wait_stat(32'h1c00, 32'h0800, 60);
      @(posedge clk);
      run[0] <= 1'b1;
      wait_stat(32'h1801, k == 0 ? 32'h0 : 32'h0800, 60);
      reg_wr(A_CTRL, 32'h6008);
    end
    reg_rd(A_STAT, d);
    chk_word(d & 32'h1c00, 32'h0800);
    reg_wr(A_CTRL, 32'h6018);
    reg_wr(A_PRIO, 32'h0011);
    wait_stat(32'h1c00, 32'h1000, 20);
    reg_wr(A_PRIO, 32'h0123);
    wait_stat(32'h1c00, 32'h1800, 20);
    reg_wr(A_CTRL, 32'h6038);
    wait_stat(32'h1c00, 32'h1000, 20);
    @(posedge clk);
    run <= 4'h0;
    wait_stat(32'h0600, 32'h0600, 60);
    @(posedge clk);
    run <= 4'hf;
    reg_wr(A_PRIO, 32'h3210);
    reg_wr(A_CTRL, 32'h6018);
    wait_stat(32'h1e00, 32'h0, 60);
    // Gapped input: no loss, no lock loss, no switch
    @(posedge clk);
    gap[0] <= 1'b1;
    for (int k = 0; k < 60; k++) begin
      reg_rd(A_STAT, d);
      chk_word(d & 32'h1e01, 32'h0);
    end
    @(posedge clk);
    gap[0] <= 1'b0;
    // Reference loss gates the outputs unless kept running
    @(posedge clk);
    ref_run <= 1'b0;
    wait_stat(32'h2010, 32'h0010, 60);
    reg_wr(A_CTRL, 32'h6218);
    wait_stat(32'h2010, 32'h2010, 20);
    @(posedge clk);
    ref_run <= 1'b1;
    wait_stat(32'h0010, 32'h0, 60);
    // Offset: slow input 2, then input 2 as the zero-ppm reference
    reg_wr(A_CTRL, 32'h18);
    @(posedge clk);
    slow[2] <= 1'b1;
    wait_stat(32'h19e0, 32'h0080, 10000);
    reg_rd(A_STICKY, d);
    chk_word(d & 32'h80, 32'h80);
    reg_wr(A_CTRL, 32'hc18);
    wait_stat(32'h19e0, 32'h1160, 10000);
    reg_wr(A_CTRL, 32'h6c18);
    wait_stat(32'h01e0, 32'h0, 20);
    report_and_stop();
  end
endmodule // testbench
